// *** hdl/channel_ring_dma.sv ***
// Transparent channel buffer ring engine with Wishbone register slave
`timescale 1ns/10ps
module channel_ring_dma #(
  parameter int RING = ring_dma_pkg::RING_LEN
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_ext_o,
  output logic [2:0] mem_fc_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_end_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic tx_starved_i,
  input wire logic carrier_detect_i,
  input wire logic clear_to_send_i,
  input wire logic layer1_grant_i
);
  import ring_dma_pkg::*;

  if (RING != RING_LEN) begin : g_chk
    $error("channel_ring_dma: descriptor map holds exactly eight per ring");
  end

  // ==========================================================
  // Storage and registers
  logic [15:0] pram [PRAM_WORDS];
  logic [15:0] bd [2*RING_LEN*BD_WORDS];
  logic [15:0] mode_r, imask_r;
  logic [7:0] event_r, evmask_r;
  eng_state_e st_r;
  logic [2:0] rx_idx, tx_idx;
  logic [15:0] rx_cnt_r, tx_cnt_r;
  logic [7:0] hold_r;
  logic hold_v_r, ovr_r, cdl_r, end_pend_r, discard_r, un_r, ct_r;
  logic [1:0] cd_s, cts_s, l1g_s;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cd_s <= 2'h3;
      cts_s <= 2'h3;
      l1g_s <= 2'h3;
    end else begin
      cd_s <= {cd_s[0], carrier_detect_i};
      cts_s <= {cts_s[0], clear_to_send_i};
      l1g_s <= {l1g_s[0], layer1_grant_i};
    end
  end

  logic nonmultiplexed_serial_mode, rx_on, tx_on, send_ok;
  assign nonmultiplexed_serial_mode = mode_r[MODE_NONMULTIPLEXED_SERIAL_MODE];
  assign rx_on = mode_r[MODE_RX_ON];
  assign tx_on = mode_r[MODE_TX_ON];
  assign send_ok = nonmultiplexed_serial_mode ? cts_s[1] : l1g_s[1];

  // ==========================================================
  // Descriptor views
  logic [15:0] rx_ctl, tx_ctl, tx_len, mrl;
  logic [31:0] rx_ptr, tx_ptr;
  assign rx_ctl = bd[{1'b0, rx_idx, W_CTL}];
  assign rx_ptr = {bd[{1'b0, rx_idx, W_PTRH}], bd[{1'b0, rx_idx, W_PTRL}]};
  assign tx_ctl = bd[{1'b1, tx_idx, W_CTL}];
  assign tx_len = bd[{1'b1, tx_idx, W_LEN}];
  assign tx_ptr = {bd[{1'b1, tx_idx, W_PTRH}], bd[{1'b1, tx_idx, W_PTRL}]};
  assign mrl = pram[PRAM_MRL_IDX];

  // ==========================================================
  // Engine descriptor write port and events
  logic eng_we;
  logic [5:0] eng_waddr;
  logic [15:0] eng_wdata;
  logic [7:0] ev_set;
  logic rx_adv, tx_adv, rx_drop, rx_close, tx_err;
  assign tx_err = un_r | ct_r;
  assign rx_drop = (st_r == ST_IDLE) && rx_on && hold_v_r && !rx_ctl[BD_OWN];
  assign rx_close = rx_on && !hold_v_r && rx_cnt_r != 16'h0000
                    && (end_pend_r || ovr_r || cdl_r);

  always_comb begin
    eng_we = 1'b0;
    eng_waddr = {1'b0, rx_idx, W_CTL};
    eng_wdata = rx_ctl;
    ev_set = 8'h00;
    rx_adv = 1'b0;
    tx_adv = 1'b0;
    case (st_r)
      ST_RX_STAT: begin
        eng_we = 1'b1;
        eng_wdata = {1'b0, rx_ctl[14:2], ovr_r, cdl_r & nonmultiplexed_serial_mode};
      end
      ST_RX_LEN: begin
        eng_we = 1'b1;
        eng_waddr = {1'b0, rx_idx, W_LEN};
        eng_wdata = rx_cnt_r;
        ev_set[EV_RX] = rx_ctl[BD_INT];
        rx_adv = 1'b1;
      end
      ST_TX_STAT: begin
        eng_we = 1'b1;
        eng_waddr = {1'b1, tx_idx, W_CTL};
        eng_wdata = {1'b0, tx_ctl[14:2], un_r, ct_r};
        ev_set[EV_TX] = tx_ctl[BD_INT] && !tx_err;
        ev_set[EV_TXERR] = tx_ctl[BD_INT] && tx_err;
        tx_adv = 1'b1;
      end
      default: begin
        ev_set[EV_BUSY] = rx_drop && !discard_r;
      end
    endcase
  end

  ring_index #(.DEPTH(RING_LEN)) u_rx_ring (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .advance_i(rx_adv),
    .wrap_i(rx_ctl[BD_WRAP]),
    .idx_o(rx_idx)
  );

  ring_index #(.DEPTH(RING_LEN)) u_tx_ring (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .advance_i(tx_adv),
    .wrap_i(tx_ctl[BD_WRAP]),
    .idx_o(tx_idx)
  );

  // ==========================================================
  // Wishbone slave
  logic wb_req, wb_go, hi_miss;
  logic [8:0] badr;
  logic [15:0] rd_data, wmerge, wold;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_go = wb_req && !eng_we;
  assign badr = wb_adr_i[8:0];
  assign hi_miss = |wb_adr_i[31:9];

  always_comb begin
    rd_data = 16'h0000;
    if (!hi_miss) begin
      if (badr < ADDR_PRAM_END) begin
        rd_data = pram[badr[6:2]];
      end else if (badr[ADDR_BD_BIT]) begin
        rd_data = bd[badr[7:2]];
      end else begin
        case (badr)
          ADDR_MODE: rd_data = mode_r;
          ADDR_EVENT: rd_data = {8'h00, event_r};
          ADDR_EVMASK: rd_data = {8'h00, evmask_r};
          ADDR_IMASK: rd_data = imask_r;
          default: rd_data = 16'h0000;
        endcase
      end
    end
  end

  assign wold = rd_data;
  assign wmerge = {wb_sel_i[1] ? wb_dat_i[15:8] : wold[15:8],
                   wb_sel_i[0] ? wb_dat_i[7:0] : wold[7:0]};

  logic wr_go;
  assign wr_go = wb_go && wb_we_i && !hi_miss;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_go && !wb_we_i) begin
        wb_dat_o <= {16'h0000, rd_data};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_go && badr < ADDR_PRAM_END) begin
      pram[badr[6:2]] <= wmerge;
    end
  end

  always_ff @(posedge clk_i) begin
    if (eng_we) begin
      bd[eng_waddr] <= eng_wdata;
    end else if (wr_go && badr[ADDR_BD_BIT]) begin
      bd[badr[7:2]] <= wmerge;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_RESET;
      evmask_r <= 8'h00;
      imask_r <= 16'h0000;
    end else if (wr_go) begin
      if (badr == ADDR_MODE) begin
        mode_r <= wmerge;
      end
      if (badr == ADDR_EVMASK) begin
        evmask_r <= wmerge[7:0];
      end
      if (badr == ADDR_IMASK) begin
        imask_r <= wmerge;
      end
    end
  end

  // Write-one clears; a new event in the same cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_r <= EVENT_RESET;
    end else begin
      event_r <= (event_r & ~((wr_go && badr == ADDR_EVENT && wb_sel_i[0])
                              ? wb_dat_i[7:0] : 8'h00)) | ev_set;
    end
  end

  // ==========================================================
  // Receive holding byte and frame flags
  logic consume;
  assign consume = (st_r == ST_RX_WR && mem_ack_i) || rx_drop;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_v_r <= 1'b0;
      hold_r <= 8'h00;
    end else if (rx_valid_i && rx_on) begin
      hold_v_r <= 1'b1;
      hold_r <= rx_data_i;
    end else if (consume) begin
      hold_v_r <= 1'b0;
    end
  end

  logic end_done;
  assign end_done = (st_r == ST_RX_LEN)
                    || (st_r == ST_IDLE && !hold_v_r && rx_cnt_r == 16'h0000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      end_pend_r <= 1'b0;
      discard_r <= 1'b0;
      ovr_r <= 1'b0;
      cdl_r <= 1'b0;
    end else begin
      end_pend_r <= rx_end_i || (end_pend_r && !end_done);
      discard_r <= rx_drop || (discard_r && !(end_pend_r && end_done));
      if (st_r == ST_RX_LEN) begin
        ovr_r <= 1'b0;
        cdl_r <= 1'b0;
      end else begin
        if (rx_valid_i && hold_v_r && !consume && rx_cnt_r != 16'h0000) begin
          ovr_r <= 1'b1;
        end
        if (nonmultiplexed_serial_mode && !cd_s[1] && rx_cnt_r != 16'h0000) begin
          cdl_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Engine state machine
  logic [15:0] rx_cnt_inc, tx_cnt_inc;
  assign rx_cnt_inc = rx_cnt_r + 16'h0001;
  assign tx_cnt_inc = tx_cnt_r + 16'h0001;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      rx_cnt_r <= 16'h0000;
      tx_cnt_r <= 16'h0000;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h00000000;
      mem_wdata_o <= 8'h00;
      mem_ext_o <= 1'b0;
      mem_fc_o <= 3'h0;
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
      un_r <= 1'b0;
      ct_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (rx_on && hold_v_r && rx_ctl[BD_OWN]) begin
            st_r <= ST_RX_WR;
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= rx_ptr + {16'h0000, rx_cnt_r};
            mem_wdata_o <= hold_r;
            mem_ext_o <= rx_ctl[BD_EXT];
            mem_fc_o <= pram[PRAM_FC_IDX][FC_RX_HI:FC_RX_LO];
          end else if (rx_close) begin
            st_r <= ST_RX_STAT;
          end else if (tx_on && tx_ctl[BD_OWN]) begin
            if (tx_cnt_r == tx_len) begin
              st_r <= ST_TX_STAT;
            end else begin
              st_r <= ST_TX_RD;
              mem_req_o <= 1'b1;
              mem_we_o <= 1'b0;
              mem_addr_o <= tx_ptr + {16'h0000, tx_cnt_r};
              mem_ext_o <= tx_ctl[BD_EXT];
              mem_fc_o <= pram[PRAM_FC_IDX][FC_TX_HI:FC_TX_LO];
            end
          end
        end
        ST_RX_WR: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            rx_cnt_r <= rx_cnt_inc;
            st_r <= (rx_cnt_inc == mrl) ? ST_RX_STAT : ST_IDLE;
          end
        end
        ST_RX_STAT: begin
          st_r <= ST_RX_LEN;
        end
        ST_RX_LEN: begin
          rx_cnt_r <= 16'h0000;
          st_r <= ST_IDLE;
        end
        ST_TX_RD: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            tx_data_o <= mem_rdata_i;
            tx_valid_o <= 1'b1;
            tx_last_o <= tx_ctl[BD_LAST] && tx_cnt_inc == tx_len;
            st_r <= ST_TX_OUT;
          end
        end
        ST_TX_OUT: begin
          if (tx_starved_i || !send_ok) begin
            un_r <= tx_starved_i;
            ct_r <= !send_ok;
            tx_valid_o <= 1'b0;
            tx_last_o <= 1'b0;
            st_r <= ST_TX_STAT;
          end else if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            tx_last_o <= 1'b0;
            tx_cnt_r <= tx_cnt_inc;
            st_r <= (tx_cnt_inc == tx_len) ? ST_TX_STAT : ST_IDLE;
          end
        end
        ST_TX_STAT: begin
          tx_cnt_r <= 16'h0000;
          un_r <= 1'b0;
          ct_r <= 1'b0;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rx_last_byte;
    st_r == ST_RX_WR && mem_ack_i && rx_cnt_inc == mrl;
  endsequence
  sequence s_tx_fetch;
    st_r == ST_TX_RD && mem_ack_i;
  endsequence
  sequence s_rx_close_pair;
    st_r == ST_RX_STAT ##1 st_r == ST_RX_LEN;
  endsequence

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
  a_rx_limit_close: assert property (s_rx_last_byte |=> s_rx_close_pair ##1 st_r == ST_IDLE)
    else $error("receive buffer not closed at maximum length");
  a_rx_empty_clear: assert property (st_r == ST_RX_STAT |-> eng_we && !eng_wdata[BD_OWN])
    else $error("receive close left empty flag set");
  a_rx_len_word: assert property (st_r == ST_RX_LEN |-> eng_wdata == rx_cnt_r
                                  && eng_waddr[1:0] == W_LEN)
    else $error("receive length word not the stored count");
  a_rx_event_post: assert property (st_r == ST_RX_LEN && rx_ctl[BD_INT] |=> event_r[EV_RX])
    else $error("receive event missing after close");
  a_ring_wrap_back: assert property (rx_adv && rx_ctl[BD_WRAP] |=> rx_idx == 3'h0)
    else $error("receive ring did not wrap");
  a_tx_fault_event: assert property (st_r == ST_TX_STAT && tx_ctl[BD_INT] && tx_err
                                     |=> event_r[EV_TXERR] && !$rose(event_r[EV_TX]))
    else $error("transmit fault event wrong");
  a_tx_ready_clear: assert property (st_r == ST_TX_STAT |-> eng_we && !eng_wdata[BD_OWN]
                                     && eng_wdata[BD_ERR1] == un_r)
    else $error("transmit close left ready set");
  a_tx_byte_out: assert property (s_tx_fetch |=> tx_valid_o && tx_data_o == $past(mem_rdata_i))
    else $error("fetched byte not presented");
  a_busy_event: assert property (rx_drop && !discard_r |=> event_r[EV_BUSY])
    else $error("busy event missing on dropped frame");
  a_owned_only: assert property ($rose(mem_req_o) && mem_we_o |-> $past(rx_ctl[BD_OWN]))
    else $error("write to buffer not owned");
  a_location_bit: assert property ($rose(mem_req_o) && mem_we_o
                                   |-> mem_ext_o == $past(rx_ctl[BD_EXT]))
    else $error("buffer location flag not honoured");
endmodule

// *** hdl/ring_dma_pkg.sv ***
// Constants and types for the transparent channel buffer ring engine
package ring_dma_pkg;
  // ==========================================================
  // Parameter memory
  localparam int PRAM_WORDS = 32;
  localparam int PRAM_GENERAL = 14;
  localparam int PRAM_SPECIFIC = 18;
  localparam logic [4:0] PRAM_FC_IDX = 5'h00;
  localparam logic [4:0] PRAM_MRL_IDX = 5'h01;
  localparam int FC_RX_HI = 14;
  localparam int FC_RX_LO = 12;
  localparam int FC_TX_HI = 6;
  localparam int FC_TX_LO = 4;
  // ==========================================================
  // Descriptor rings
  localparam int RING_LEN = 8;
  localparam int BD_WORDS = 4;
  localparam logic [1:0] W_CTL = 2'h0;
  localparam logic [1:0] W_LEN = 2'h1;
  localparam logic [1:0] W_PTRH = 2'h2;
  localparam logic [1:0] W_PTRL = 2'h3;
  localparam int BD_OWN = 15;
  localparam int BD_EXT = 14;
  localparam int BD_WRAP = 13;
  localparam int BD_INT = 12;
  localparam int BD_LAST = 11;
  localparam int BD_ERR1 = 1;
  localparam int BD_ERR0 = 0;
  // ==========================================================
  // Register byte addresses
  localparam logic [8:0] ADDR_PRAM_END = 9'h080;
  localparam logic [8:0] ADDR_MODE = 9'h080;
  localparam logic [8:0] ADDR_EVENT = 9'h084;
  localparam logic [8:0] ADDR_EVMASK = 9'h088;
  localparam logic [8:0] ADDR_IMASK = 9'h08C;
  localparam int ADDR_BD_BIT = 8;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam int MODE_RX_ON = 0;
  localparam int MODE_TX_ON = 1;
  localparam int MODE_NONMULTIPLEXED_SERIAL_MODE = 2;
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_BUSY = 2;
  localparam int EV_TXERR = 4;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  // ==========================================================
  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX_WR, ST_RX_STAT, ST_RX_LEN, ST_TX_RD, ST_TX_OUT, ST_TX_STAT
  } eng_state_e;
endpackage

// *** hdl/ring_index.sv ***
// Descriptor ring position counter
`timescale 1ns/10ps
module ring_index #(
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic advance_i,
  input wire logic wrap_i,
  output logic [$clog2(DEPTH)-1:0] idx_o
);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("ring_index: DEPTH must be a power of two, at least 2");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_o <= '0;
    end else if (advance_i) begin
      if (wrap_i) begin
        idx_o <= '0;
      end else begin
        idx_o <= idx_o + 1'b1;
      end
    end
  end
endmodule

// *** verification/buffer_memory_model.sv ***
// Behavioural buffer memory that answers the engine's byte requests
`timescale 1ns/10ps
module buffer_memory_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  logic [2:0] cnt;
  initial begin
    ack_o = 1'b0;
    rdata_o = 8'h00;
    cnt = 3'h0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
  end
  // One byte per request; read data is only meaningful with the acknowledge
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    if (req_i && !ack_o && cnt >= (slow_i ? 3'h5 : 3'h1)) begin
      ack_o <= 1'b1;
      cnt <= 3'h0;
      if (we_i) begin
        mem[addr_i[7:0]] <= wdata_i;
      end else begin
        rdata_o <= mem[addr_i[7:0]];
      end
    end else begin
      cnt <= (req_i && !ack_o) ? cnt + 3'h1 : 3'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// *** verification/transparent_channel_buffer_rings_test.sv ***
// Self-checking bench for the channel buffer ring engine
`timescale 1ns/10ps
module transparent_channel_buffer_rings_test;
  import ring_dma_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, rx_valid_i, rx_end_i, tx_ready_i, tx_starved_i;
  logic carrier_detect_i, clear_to_send_i, layer1_grant_i, slow, wb_ack_o, mem_ack_i;
  logic mem_req_o, mem_we_o, mem_ext_o, tx_valid_o, tx_last_o, last_ext;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, mem_addr_o;
  logic [3:0] wb_sel_i;
  logic [7:0] rx_data_i, tx_data_o, mem_wdata_o, mem_rdata_i;
  logic [2:0] mem_fc_o, last_fc;
  logic [8:0] txq [$];
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  channel_ring_dma dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ext_o(mem_ext_o),
    .mem_fc_o(mem_fc_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_end_i(rx_end_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i), .tx_starved_i(tx_starved_i), .carrier_detect_i(carrier_detect_i),
    .clear_to_send_i(clear_to_send_i), .layer1_grant_i(layer1_grant_i));
  buffer_memory_model mem (.clk_i(clk_i), .slow_i(slow), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  always #2.5 clk_i = ~clk_i;

  // ==========================================================
  // Monitors and timeout
  always @(posedge clk_i) begin
    if (tx_valid_o === 1'b1 && tx_ready_i) begin
      txq.push_back({tx_last_o, tx_data_o});
    end
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
      last_ext <= mem_ext_o;
      last_fc <= mem_fc_o;
    end
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      print_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] a32(input logic [8:0] a);
    return {23'h000000, a};
  endfunction

  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      chk(32'h0, 32'h1, "bus answer");
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e, what);
  endtask

  // Control word goes last so the engine never sees a half-built descriptor
  task automatic desc(input logic [31:0] b, input logic [15:0] c, input logic [15:0] l,
                      input logic [31:0] p);
    wr(b + 32'h4, {16'h0000, l});
    wr(b + 32'h8, {16'h0000, p[31:16]});
    wr(b + 32'hC, {16'h0000, p[15:0]});
    wr(b, {16'h0000, c});
  endtask

  task automatic rx_byte(input logic [7:0] d, input int gap);
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    rx_data_i <= d;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_regs();
    rdchk(a32(ADDR_MODE), 32'h0, "mode after reset");
    // Descriptor memory powers up unknown: hand every descriptor back to software first
    for (int i = 0; i < 2 * RING_LEN; i++) begin
      wr(32'h100 + 32'h10 * i, 32'h0);
    end
    wr(a32(ADDR_EVMASK), 32'h1FF);
    rdchk(a32(ADDR_EVMASK), 32'hFF, "event mask");
    wr(a32(ADDR_IMASK), 32'hA5A5);
    rdchk(a32(ADDR_IMASK), 32'hA5A5, "interrupt mask");
    wr(32'h0, 32'hFFFF3050);
    rdchk(32'h0, 32'h00003050, "function codes");
    wr(32'h4, 32'h4);
    rdchk(32'h4, 32'h4, "max length");
    wr(32'h7C, 32'hBEEF);
    rdchk(32'h7C, 32'hBEEF, "last parameter word");
    wr(32'h200, 32'h1234);
    rdchk(32'h200, 32'h0, "unmapped read");
    wr(a32(ADDR_EVENT), 32'hFF);
    $display("test_regs finished");
  endtask

  task automatic test_rx_fill();
    wr(a32(ADDR_MODE), 32'h5);
    desc(32'h100, 16'hD000, 16'h0, 32'h10);
    for (int i = 0; i < 5; i++) begin
      rx_byte(8'hC0 + i[7:0], 12);
    end
    // End the frame so the busy report is armed again for the next one
    rx_end_i <= 1'b1;
    @(posedge clk_i);
    rx_end_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdchk(32'h100, 32'h5000, "rx control after fill");
    rdchk(32'h104, 32'h4, "rx length");
    for (int i = 0; i < 4; i++) begin
      chk({24'h0, mem.mem[16 + i]}, {24'h0, 8'hC0 + i[7:0]}, "rx byte stored");
    end
    chk({24'h0, mem.mem[20]}, {24'h0, 8'h14 ^ 8'h5A}, "byte past limit");
    chk({31'h0, last_ext}, 32'h1, "rx location");
    chk({29'h0, last_fc}, 32'h3, "rx function code");
    rdchk(a32(ADDR_EVENT), 32'h05, "rx and busy events");
    wr(a32(ADDR_EVENT), 32'h0);
    rdchk(a32(ADDR_EVENT), 32'h05, "zero write keeps events");
    wr(a32(ADDR_EVENT), 32'h1);
    rdchk(a32(ADDR_EVENT), 32'h04, "one write clears event");
    wr(a32(ADDR_EVENT), 32'hFF);
    $display("test_rx_fill finished");
  endtask

  task automatic test_rx_overrun();
    slow <= 1'b1;
    desc(32'h110, 16'hA000, 16'h0, 32'h40);
    rx_byte(8'h11, 12);
    rx_byte(8'h22, 0);
    rx_byte(8'h33, 30);
    rdchk(32'h110, 32'h2002, "overrun status");
    rdchk(a32(ADDR_EVENT), 32'h0, "no event without flag");
    rx_byte(8'h44, 0);
    rx_end_i <= 1'b1;
    @(posedge clk_i);
    rx_end_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rdchk(a32(ADDR_EVENT), 32'h04, "busy after wrap");
    rdchk(32'h100, 32'h5000, "closed descriptor untouched");
    wr(a32(ADDR_EVENT), 32'hFF);
    slow <= 1'b0;
    $display("test_rx_overrun finished");
  endtask

  task automatic rx_carrier(input logic [31:0] md, input logic [31:0] b,
                            input logic [15:0] c, input logic [31:0] e);
    wr(a32(ADDR_MODE), md);
    desc(b, c, 16'h0, 32'h50);
    rx_byte(8'h66, 12);
    carrier_detect_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    carrier_detect_i <= 1'b1;
    rx_end_i <= 1'b1;
    @(posedge clk_i);
    rx_end_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rdchk(b, e, "carrier status");
    wr(a32(ADDR_EVENT), 32'hFF);
  endtask

  task automatic test_tx();
    wr(a32(ADDR_MODE), 32'h7);
    desc(32'h180, 16'h9800, 16'h2, 32'h20);
    for (int n = 0; n < 100 && txq.size() < 2; n++) begin
      @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    chk({23'h0, txq.size() > 0 ? txq[0] : 9'h000}, {24'h0, 8'h7A}, "first tx byte");
    chk({23'h0, txq.size() > 1 ? txq[1] : 9'h000}, {23'h0, 9'h17B}, "last tx byte");
    rdchk(32'h180, 32'h1800, "tx control after send");
    rdchk(a32(ADDR_EVENT), 32'h02, "tx event");
    chk({31'h0, last_ext}, 32'h0, "tx location");
    chk({29'h0, last_fc}, 32'h5, "tx function code");
    wr(a32(ADDR_EVENT), 32'hFF);
    $display("test_tx finished");
  endtask

  task automatic tx_fault(input logic [31:0] b, input logic [15:0] c, input int kind,
                          input logic [31:0] e);
    tx_ready_i <= 1'b0;
    desc(b, c, 16'h3, 32'h30);
    for (int n = 0; n < 100 && tx_valid_o !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    tx_starved_i <= (kind == 1);
    clear_to_send_i <= (kind != 0);
    layer1_grant_i <= (kind != 2);
    repeat (6) @(posedge clk_i);
    tx_starved_i <= 1'b0;
    clear_to_send_i <= 1'b1;
    layer1_grant_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdchk(b, e, "tx fault status");
    rdchk(a32(ADDR_EVENT), 32'h10, "tx fault event");
    wr(a32(ADDR_EVENT), 32'hFF);
    tx_ready_i <= 1'b1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, rx_valid_i, rx_end_i, tx_starved_i, slow} = 7'h00;
    {carrier_detect_i, clear_to_send_i, layer1_grant_i, tx_ready_i} = 4'hF;
    {wb_adr_i, wb_dat_i, wb_sel_i, rx_data_i} = 76'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_rx_fill();
    test_rx_overrun();
    rx_carrier(32'h5, 32'h100, 16'h9000, 32'h1001);
    rx_carrier(32'h1, 32'h110, 16'hA000, 32'h2000);
    $display("carrier tests finished");
    test_tx();
    tx_fault(32'h190, 16'hB000, 0, 32'h3001);
    tx_fault(32'h180, 16'h9000, 1, 32'h1002);
    wr(a32(ADDR_MODE), 32'h3);
    tx_fault(32'h190, 16'hB000, 2, 32'h3001);
    $display("tx fault tests finished");
    print_verdict();
  end
endmodule
